// *** hw/bbfc_pkg.sv ***
package bbfc_pkg;
    // command codes written on the data pins
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
    localparam logic [7:0] CMD_PROG_ALT = 8'h10;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_SIGNATURE = 8'h90;
    // status bit positions
    localparam int SR_READY = 7;
    localparam int SR_SUSP = 6;
    localparam int SR_ERASE_ERR = 5;
    localparam int SR_PROG_ERR = 4;
    localparam int SR_VPP_LOW = 3;
    // widths
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    // signature addresses
    localparam logic [16:0] SIG_MFG_ADDR = 17'h0_0000;
    localparam logic [16:0] SIG_DEV_ADDR = 17'h0_0001;
    // bus timing at 50 ns clock
    localparam int CLK_NS = 50;
    localparam int WE_LOW_NS = 40;
    localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_NS = 40;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACCESS_NS = 150;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_NS = 600;
    localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
    // embedded operation bounds and typical times in milliseconds
    localparam int BOOT_ERASE_MS = 14900;
    localparam int PARAM_ERASE_MS = 14600;
    localparam int MAIN_ERASE_MS = 20900;
    localparam int CHIP_ERASE_MS = 65000;
    localparam int BOOT_PROG_MS = 520;
    localparam int MAIN_PROG_MS = 7340;
    localparam int TYP_BOOT_ERASE_MS = 2100;
    localparam int TYP_MAIN_ERASE_MS = 3800;
    localparam int TYP_CHIP_ERASE_MS = 10100;
    localparam int TYP_BOOT_PROG_MS = 150;
    localparam int TYP_MAIN_PROG_MS = 2100;
    localparam int CYC_PER_MS = 1000000 / CLK_NS;
    // host operations
    typedef enum logic [2:0] {
        BBFC_OP_READ,
        BBFC_OP_WRITE1,
        BBFC_OP_PROGRAM,
        BBFC_OP_ERASE,
        BBFC_OP_POLL,
        BBFC_OP_SIG_HV
    } bbfc_op_t;
    // block class selects the erase timeout
    typedef enum logic [1:0] {
        BBFC_BLK_BOOT,
        BBFC_BLK_PARAM,
        BBFC_BLK_MAIN,
        BBFC_BLK_CHIP
    } bbfc_blk_t;
    // request from the user side
    typedef struct packed {
        bbfc_op_t op;
        bbfc_blk_t blk;
        logic [16:0] addr;
        logic [7:0] data;
    } bbfc_req_t;
    // pins driven toward the flash
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic powerdown_n;
        logic address_bit_nine; // high-voltage level on address bit nine
        logic [16:0] address_inputs;
        logic [7:0] data_out;
        logic data_oe_n;
    } bbfc_pins_t;
endpackage

// *** hw/bbfc_timer.sv ***
module bbfc_timer #(
    parameter int W = 32
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic [W-1:0] limit,
    output logic expired
);
    logic [W-1:0] cnt_r; // cycles left
    logic run_r; // counting
    // loads on start, flags once count reaches zero
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
            run_r <= 1'b0;
            expired <= 1'b0;
        end else if (start) begin
            cnt_r <= limit;
            run_r <= 1'b1;
            expired <= 1'b0;
        end else if (run_r) begin
            if (cnt_r == '0) begin
                run_r <= 1'b0;
                expired <= 1'b1;
            end else begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

// *** hw/bbfc_host.sv ***
// Operation
// - single FFH write returns array reads
// - commands are one or two write cycles
// - program is 40H then address and data
// - 70H makes reads return status
// - failure flags cleared only by 50H
// - erase is 20H then D0H in block
// - B0H suspends erase, D0H resumes it
// - signature by high voltage or command
// - high-voltage signature keeps other address low
module bbfc_host #(
    parameter int CYC_PER_MS = bbfc_pkg::CYC_PER_MS
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire bbfc_pkg::bbfc_req_t req,
    input wire logic sleep,
    output logic req_ready,
    output logic done,
    output logic [7:0] rd_data,
    output logic timeout,
    output logic op_error,
    output bbfc_pkg::bbfc_pins_t pins,
    input wire logic [7:0] data_in
);
    typedef enum {
        S_WAKE, S_IDLE, S_SETUP, S_WE_LOW, S_WE_HIGH, S_RD_SETUP, S_RD_WAIT,
        S_POLL_GAP, S_DONE, S_SLEEP
    } bbfc_state_t;
    bbfc_state_t state_r; // bus sequencer state
    bbfc_pkg::bbfc_req_t cur_r; // request in progress
    logic second_r; // second write of a pair pending
    logic [7:0] data_s1_r; // first sync stage
    logic [7:0] data_s2_r; // second sync stage
    logic [3:0] wait_r; // bus phase counter
    logic tmr_start_r; // arms the embedded timeout
    logic [31:0] tmr_limit_r; // timeout in cycles
    logic tmr_exp; // timeout expired

    // worst-case timeout per block class and operation
    function automatic logic [31:0] limit_of(input bbfc_pkg::bbfc_req_t r);
        int ms;
        ms = bbfc_pkg::MAIN_PROG_MS;
        if (r.op == bbfc_pkg::BBFC_OP_ERASE) begin
            case (r.blk)
                bbfc_pkg::BBFC_BLK_BOOT: ms = bbfc_pkg::BOOT_ERASE_MS;
                bbfc_pkg::BBFC_BLK_PARAM: ms = bbfc_pkg::PARAM_ERASE_MS;
                bbfc_pkg::BBFC_BLK_MAIN: ms = bbfc_pkg::MAIN_ERASE_MS;
                default: ms = bbfc_pkg::CHIP_ERASE_MS;
            endcase
        end else if (r.blk == bbfc_pkg::BBFC_BLK_BOOT) begin
            ms = bbfc_pkg::BOOT_PROG_MS;
        end
        return 32'(ms * CYC_PER_MS);
    endfunction

    bbfc_timer #(.W(32)) u_timer (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .start(tmr_start_r),
        .limit(tmr_limit_r),
        .expired(tmr_exp)
    );

    // read data comes from another domain, so two flops first
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            data_s1_r <= '0;
            data_s2_r <= '0;
        end else begin
            data_s1_r <= data_in;
            data_s2_r <= data_s1_r;
        end
    end

    // main bus sequencer
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= S_WAKE;
            cur_r <= '0;
            second_r <= 1'b0;
            wait_r <= '0;
            tmr_start_r <= 1'b0;
            tmr_limit_r <= '0;
            req_ready <= 1'b0;
            done <= 1'b0;
            rd_data <= '0;
            timeout <= 1'b0;
            op_error <= 1'b0;
            pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, powerdown_n: 1'b0,
                       address_bit_nine: 1'b0, address_inputs: '0, data_out: '0,
                       data_oe_n: 1'b1};
        end else begin
            done <= 1'b0;
            tmr_start_r <= 1'b0;
            case (state_r)
                S_WAKE: begin
                    // device returns to array read mode on wake
                    pins.powerdown_n <= 1'b1;
                    wait_r <= wait_r + 1'b1;
                    if (wait_r == 4'(bbfc_pkg::WAKE_CYC)) begin
                        state_r <= S_IDLE;
                        req_ready <= 1'b1;
                    end
                end
                S_IDLE: begin
                    pins.ce_n <= 1'b1; // standby between accesses
                    pins.address_bit_nine <= 1'b0;
                    wait_r <= '0;
                    if (sleep) begin
                        pins.powerdown_n <= 1'b0; // overrides all pins
                        req_ready <= 1'b0;
                        state_r <= S_SLEEP;
                    end else if (req_valid) begin
                        cur_r <= req;
                        req_ready <= 1'b0;
                        timeout <= 1'b0;
                        op_error <= 1'b0;
                        pins.ce_n <= 1'b0;
                        if (req.op == bbfc_pkg::BBFC_OP_SIG_HV) begin
                            // only bit zero may be high besides bit nine
                            pins.address_inputs <= {16'h0000, req.addr[0]};
                            pins.address_bit_nine <= 1'b1;
                            state_r <= S_RD_SETUP;
                        end else if (req.op == bbfc_pkg::BBFC_OP_READ) begin
                            pins.address_inputs <= req.addr;
                            state_r <= S_RD_SETUP;
                        end else begin
                            pins.address_inputs <= req.addr;
                            second_r <= (req.op == bbfc_pkg::BBFC_OP_PROGRAM) ||
                                        (req.op == bbfc_pkg::BBFC_OP_ERASE);
                            // setup code first, same block address
                            pins.data_out <= (req.op == bbfc_pkg::BBFC_OP_PROGRAM) ?
                                bbfc_pkg::CMD_PROG_SETUP :
                                (req.op == bbfc_pkg::BBFC_OP_ERASE) ?
                                bbfc_pkg::CMD_ERASE_SETUP :
                                (req.op == bbfc_pkg::BBFC_OP_POLL) ?
                                bbfc_pkg::CMD_READ_STATUS : req.data;
                            pins.data_oe_n <= 1'b0;
                            state_r <= S_SETUP;
                        end
                    end
                end
                S_SETUP: begin
                    // write cycle: ce and we low, oe high
                    pins.oe_n <= 1'b1;
                    pins.we_n <= 1'b0;
                    state_r <= S_WE_LOW;
                    wait_r <= '0;
                end
                S_WE_LOW: begin
                    wait_r <= wait_r + 1'b1;
                    if (wait_r + 1'b1 >= 4'(bbfc_pkg::WE_LOW_CYC)) begin
                        pins.we_n <= 1'b1; // device latches on rising edge
                        state_r <= S_WE_HIGH;
                    end
                end
                S_WE_HIGH: begin
                    wait_r <= '0;
                    if (second_r) begin
                        second_r <= 1'b0;
                        pins.data_out <= (cur_r.op == bbfc_pkg::BBFC_OP_ERASE) ?
                            bbfc_pkg::CMD_CONFIRM : cur_r.data;
                        state_r <= S_SETUP;
                    end else if (cur_r.op == bbfc_pkg::BBFC_OP_WRITE1) begin
                        // FFH, 50H, 90H, B0H, D0H go out as single writes
                        pins.data_oe_n <= 1'b1;
                        state_r <= S_DONE;
                    end else begin
                        // program/erase leave the device in status mode
                        pins.data_oe_n <= 1'b1;
                        if (cur_r.op != bbfc_pkg::BBFC_OP_POLL) begin
                            tmr_limit_r <= limit_of(cur_r);
                            tmr_start_r <= 1'b1;
                        end
                        state_r <= S_RD_SETUP;
                    end
                end
                S_RD_SETUP: begin
                    // read: ce and oe low, we high, any supply level
                    pins.data_oe_n <= 1'b1;
                    pins.we_n <= 1'b1;
                    pins.oe_n <= 1'b0;
                    pins.ce_n <= 1'b0;
                    wait_r <= '0;
                    state_r <= S_RD_WAIT;
                end
                S_RD_WAIT: begin
                    // allow access time plus two sync stages
                    wait_r <= wait_r + 1'b1;
                    if (wait_r == 4'(bbfc_pkg::ACCESS_CYC + 2)) begin
                        rd_data <= data_s2_r;
                        pins.oe_n <= 1'b1; // disable: ce low, oe high floats
                        if (cur_r.op == bbfc_pkg::BBFC_OP_PROGRAM ||
                            cur_r.op == bbfc_pkg::BBFC_OP_ERASE) begin
                            if (data_s2_r[bbfc_pkg::SR_READY]) begin
                                op_error <= data_s2_r[bbfc_pkg::SR_ERASE_ERR] |
                                            data_s2_r[bbfc_pkg::SR_PROG_ERR] |
                                            data_s2_r[bbfc_pkg::SR_VPP_LOW];
                                state_r <= S_DONE;
                            end else if (tmr_exp) begin
                                timeout <= 1'b1;
                                state_r <= S_DONE;
                            end else begin
                                state_r <= S_POLL_GAP; // latch needs oe toggle
                            end
                        end else begin
                            state_r <= S_DONE;
                        end
                    end
                end
                S_POLL_GAP: begin
                    state_r <= S_RD_SETUP;
                end
                S_DONE: begin
                    pins.ce_n <= 1'b1;
                    pins.oe_n <= 1'b1;
                    pins.address_bit_nine <= 1'b0;
                    done <= 1'b1;
                    req_ready <= 1'b1;
                    state_r <= S_IDLE;
                end
                S_SLEEP: begin
                    if (!sleep) begin
                        wait_r <= '0;
                        state_r <= S_WAKE;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule

// *** verif/bbfc_checker.sv ***
module bbfc_checker #(
    parameter int CYC_PER_MS = bbfc_pkg::CYC_PER_MS
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire bbfc_pkg::bbfc_req_t req,
    input wire logic sleep,
    input wire logic req_ready,
    input wire logic done,
    input wire logic [7:0] rd_data,
    input wire logic timeout,
    input wire logic op_error,
    input wire bbfc_pkg::bbfc_pins_t pins,
    input wire logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // a write strobe opens only inside a selected, output-disabled cycle
    sequence s_wr_open;
        !pins.ce_n && pins.oe_n && !pins.data_oe_n;
    endsequence
    // strobe closes with address and data still held, so the latch is clean
    sequence s_wr_close;
        pins.we_n && !pins.ce_n && $stable(pins.data_out) && $stable(pins.address_inputs);
    endsequence
    chk_wr_open: assert property ($fell(pins.we_n) |-> s_wr_open)
        else $error("write strobe outside a write cycle");
    chk_wr_close: assert property ($fell(pins.we_n) |=> s_wr_close)
        else $error("write strobe did not close cleanly");
    chk_read_bus: assert property (!pins.oe_n |-> pins.data_oe_n && pins.we_n && !pins.ce_n)
        else $error("read with host driving data");
    chk_idle_float: assert property (req_ready |-> pins.ce_n && pins.we_n && pins.data_oe_n)
        else $error("idle bus not in standby");
    chk_hv_addr: assert property (pins.address_bit_nine |-> pins.address_inputs[16:1] == 16'h0000)
        else $error("upper address not low during high voltage read");
    chk_sleep_pd: assert property (sleep && req_ready |-> ##[1:3] !pins.powerdown_n)
        else $error("sleep did not reach power-down");
    chk_pd_quiet: assert property (!pins.powerdown_n |-> pins.ce_n && pins.we_n)
        else $error("strobes active in power-down");
    chk_wake_gap: assert property ($rose(pins.powerdown_n) |-> !req_ready [*8])
        else $error("request accepted before wake-up");
    chk_take_once: assert property (req_valid && req_ready && !sleep |=> !req_ready)
        else $error("ready stayed high after a take");
    chk_done_pulse: assert property (done |=> !done)
        else $error("done longer than one cycle");
endmodule
bind bbfc_host bbfc_checker #(.CYC_PER_MS(CYC_PER_MS)) u_chk (
    .ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid), .req(req), .sleep(sleep),
    .req_ready(req_ready), .done(done), .rd_data(rd_data), .timeout(timeout),
    .op_error(op_error), .pins(pins), .data_in(data_in));

// *** verif/bbfc_flash_model.sv ***
module bbfc_flash_model #(
    parameter logic [7:0] MFG_CODE = 8'h5c, // arbitrary maker code
    parameter logic [7:0] DEV_CODE = 8'ha3 // arbitrary part code
) (
    input wire bbfc_pkg::bbfc_pins_t pins,
    input wire logic hang,
    input wire logic fail,
    output logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:255]; // low address byte only, enough for the bench
    logic [7:0] sr; // status flags, ready bit derived from busy
    logic [7:0] v, last;
    logic drv;
    int mode; // 0 array, 1 status, 2 signature
    int setup; // pending first cycle: 1 program, 2 erase
    int busy; // status reads left before ready; hang freezes it
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5a;
        sr = 8'h00;
        mode = 0;
        setup = 0;
        busy = 0;
        last = 8'h00;
    end
    // leaving power-down always lands in array reads
    always @(negedge pins.powerdown_n) begin
        mode = 0;
        setup = 0;
    end
    // command and data latched as write enable rises
    always @(posedge pins.we_n) if (pins.powerdown_n && !pins.ce_n) begin
        if (setup != 0) begin
            if (setup == 2 && pins.data_out != bbfc_pkg::CMD_CONFIRM) sr[5:4] = 2'b11;
            else begin
                if (setup == 1) mem[pins.address_inputs[7:0]] = pins.data_out;
                if (fail) sr[setup == 1 ? 4 : 5] = 1'b1;
                busy = 3;
            end
            mode = 1;
            setup = 0;
        end else case (pins.data_out)
            bbfc_pkg::CMD_READ_ARRAY: mode = 0;
            bbfc_pkg::CMD_READ_STATUS: mode = 1;
            bbfc_pkg::CMD_CLEAR_STATUS: sr[5:3] = 3'b000;
            bbfc_pkg::CMD_SIGNATURE: mode = 2;
            bbfc_pkg::CMD_PROG_SETUP, bbfc_pkg::CMD_PROG_ALT: setup = 1;
            bbfc_pkg::CMD_ERASE_SETUP: setup = 2;
            bbfc_pkg::CMD_SUSPEND: begin
                sr[6] = (busy != 0);
                mode = 1;
            end
            bbfc_pkg::CMD_CONFIRM: sr[6] = 1'b0;
            default: ;
        endcase
    end
    // each finished status read moves the embedded operation along
    always @(posedge pins.oe_n) if (mode == 1 && busy > 0 && !hang) busy--;
    // high voltage on bit nine overrides the read mode
    always @* begin
        if (pins.address_bit_nine || mode == 2) v = pins.address_inputs[0] ? DEV_CODE : MFG_CODE;
        else if (mode == 1) v = {busy == 0 || sr[6], sr[6:0]};
        else v = mem[pins.address_inputs[7:0]];
    end
    // no supply pin modelled: reads never depend on it
    assign drv = pins.powerdown_n && !pins.ce_n && !pins.oe_n && pins.we_n;
    always @* if (drv) last = v;
    // released bus shows the inverse, so a stale value never looks right
    assign data_in = drv ? v : ~last;
endmodule

// *** verif/tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] MFG = 8'h5c; // arbitrary maker code
    localparam logic [7:0] DEV = 8'ha3; // arbitrary part code
    localparam bbfc_pkg::bbfc_op_t RD = bbfc_pkg::BBFC_OP_READ;
    localparam bbfc_pkg::bbfc_op_t W1 = bbfc_pkg::BBFC_OP_WRITE1;
    localparam bbfc_pkg::bbfc_op_t PG = bbfc_pkg::BBFC_OP_PROGRAM;
    localparam bbfc_pkg::bbfc_op_t PL = bbfc_pkg::BBFC_OP_POLL;
    localparam bbfc_pkg::bbfc_blk_t BM = bbfc_pkg::BBFC_BLK_MAIN;
    localparam bbfc_pkg::bbfc_blk_t BB = bbfc_pkg::BBFC_BLK_BOOT;
    logic ref_clk, nrst, req_valid, sleep, hang, fail;
    logic req_ready, done, timeout, op_error;
    logic [7:0] rd_data, data_in, d;
    logic [16:0] a;
    logic [31:0] lf = 32'h0000_ae8d; // random source
    logic [10:0] q [$]; // notes: {check data, timeout, error, data}
    logic [10:0] e;
    bbfc_pkg::bbfc_req_t req;
    bbfc_pkg::bbfc_pins_t pins;
    int err_count = 0;
    int tests_run = 0;
    bbfc_host #(.CYC_PER_MS(2)) DUT (.ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid),
        .req(req), .sleep(sleep), .req_ready(req_ready), .done(done), .rd_data(rd_data),
        .timeout(timeout), .op_error(op_error), .pins(pins), .data_in(data_in));
    bbfc_flash_model #(.MFG_CODE(MFG), .DEV_CODE(DEV)) u_flash (.pins(pins), .hang(hang),
        .fail(fail), .data_in(data_in));
    always #25 ref_clk = ~ref_clk;
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // one request: note the outcome, hold until taken, wait for done
    task automatic run(input bbfc_pkg::bbfc_op_t o, input bbfc_pkg::bbfc_blk_t b,
            input logic [16:0] ad, input logic [7:0] dt, input logic [10:0] ex);
        int n;
        n = 0;
        q.push_back(ex);
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req <= '{o, b, ad, dt};
        do @(negedge ref_clk); while (req_ready !== 1'b1 && n++ < 4000);
        @(posedge ref_clk);
        req_valid <= 1'b0;
        n = 0;
        do @(negedge ref_clk); while (done !== 1'b1 && n++ < 40000);
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // result watcher: each done retires the oldest note
    always @(negedge ref_clk) if (done === 1'b1) begin
        tests_run++;
        e = (q.size() > 0) ? q.pop_front() : 11'h7ff;
        if ((e[10] && rd_data !== e[7:0]) || op_error !== e[8] || timeout !== e[9]) begin
            err_count++;
            $display("[ERR] %0t result %h err %b to %b, note %h", $time, rd_data, op_error,
                timeout, e);
        end
    end
    // hang guard, far beyond the 1040-cycle boot program bound but below the 40000-cycle done wait in run
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test;
    end
    initial begin
        ref_clk = 1'b0;
        nrst = 1'b0;
        req_valid = 1'b0;
        req = '0;
        sleep = 1'b0;
        hang = 1'b0;
        fail = 1'b0;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        // random array reads straight after power-up
        for (int i = 0; i < 6; i++) begin
            lf = step(lf);
            a = lf[16:0];
            run(RD, BM, a, 8'h00, {3'b100, a[7:0] ^ 8'h5a});
        end
        lf = step(lf);
        d = lf[7:0];
        run(PG, BB, 17'h0_0123, d, {3'b100, 8'h80});
        run(W1, BM, 17'h1_ffff, bbfc_pkg::CMD_READ_ARRAY, 11'h000);
        run(RD, BM, 17'h0_0123, 8'h00, {3'b100, d});
        run(W1, BM, 17'h0_0000, bbfc_pkg::CMD_SIGNATURE, 11'h000);
        run(RD, BM, bbfc_pkg::SIG_MFG_ADDR, 8'h00, {3'b100, MFG});
        run(RD, BM, bbfc_pkg::SIG_DEV_ADDR, 8'h00, {3'b100, DEV});
        run(W1, BM, 17'h0_0000, bbfc_pkg::CMD_READ_ARRAY, 11'h000);
        run(bbfc_pkg::BBFC_OP_SIG_HV, BM, 17'h1_ff01, 8'h00, {3'b100, DEV});
        // failing erase: flag sticks until cleared
        fail <= 1'b1;
        run(bbfc_pkg::BBFC_OP_ERASE, bbfc_pkg::BBFC_BLK_PARAM, 17'h1_e000, 8'h00,
            {3'b101, 8'ha0});
        fail <= 1'b0;
        // a plain status poll reports the sticky flag in the data, not as an error
        run(PL, BM, 17'h0_0000, 8'h00, {3'b100, 8'ha0});
        run(W1, BM, 17'h0_0000, bbfc_pkg::CMD_CLEAR_STATUS, 11'h000);
        run(PL, BM, 17'h0_0000, 8'h00, {3'b100, 8'h80});
        // stuck operation: bound expires, then suspend and resume
        hang <= 1'b1;
        run(PG, BB, 17'h0_0124, 8'h00, 11'h200);
        run(W1, BM, 17'h0_0000, bbfc_pkg::CMD_SUSPEND, 11'h000);
        run(PL, BM, 17'h0_0000, 8'h00, {3'b100, 8'hc0});
        run(W1, BM, 17'h0_0000, bbfc_pkg::CMD_CONFIRM, 11'h000);
        run(PL, BM, 17'h0_0000, 8'h00, {3'b100, 8'h00});
        hang <= 1'b0;
        // power-down drops status mode back to array reads
        @(posedge ref_clk);
        sleep <= 1'b1;
        repeat (20) @(posedge ref_clk);
        sleep <= 1'b0;
        run(RD, BM, 17'h0_0042, 8'h00, {3'b100, 8'h42 ^ 8'h5a});
        stop_test;
    end
endmodule
